//--- design/tbce_pkg.sv
// Shared constants, types and helpers for the toggle/branch/call/clear slice
`default_nettype none

package tbce_pkg;

  // ==========================================================================
  // Widths as types
  typedef logic [15:0] tbce_word_type;
  typedef logic [20:0] tbce_pc_type;
  typedef logic [11:0] tbce_daddr_type;
  typedef logic [7:0]  tbce_byte_type;
  typedef logic [4:0]  tbce_status_type;
  typedef logic [3:0]  tbce_bank_type;

  // ==========================================================================
  // Opcode patterns, compared against the top bits of the first word; OPC_CALL_2ND is the second word's and is never compared
  localparam logic [3:0] OPC_TOGGLE    = 4'h7;        // 0111 bbba
  localparam logic [7:0] OPC_BRANCH_SX = 8'hE4;       // 1110 0100
  localparam logic [7:0] OPC_BRANCH_Z  = 8'hE0;       // 1110 0000
  localparam logic [6:0] OPC_CALL      = 7'h76;       // 1110 110s
  localparam logic [3:0] OPC_CALL_2ND  = 4'hF;        // 1111 kkkk
  localparam logic [6:0] OPC_CLEAR     = 7'h35;       // 0110 101a

  // Instruction field positions
  localparam int BANK_BIT   = 8;                      // a bit of file ops
  localparam int SHADOW_BIT = 8;                      // s bit of the call
  localparam int BIT_LSB    = 9;                      // bbb field, low end

  // Status register bit positions
  localparam int ST_ZERO = 2;
  localparam int ST_EXCESS = 3;

  // ==========================================================================
  // Addressing and program counter constants
  localparam tbce_byte_type INDEX_LIMIT = 8'h5F;      // 95, highest indexed f
  localparam tbce_bank_type LOW_BANK    = 4'h0;
  localparam tbce_pc_type   PC_STEP     = 21'h000002;
  localparam tbce_pc_type   CALL_RET    = 21'h000004;

  // Reset values
  localparam tbce_pc_type     PC_RST     = 21'h000000;
  localparam tbce_word_type   WORD_RST   = 16'h0000;
  localparam tbce_daddr_type  DADDR_RST  = 12'h000;
  localparam tbce_byte_type   BYTE_ZERO  = 8'h00;
  localparam tbce_status_type STATUS_RST = 5'h00;
  localparam tbce_bank_type   BANK_RST   = 4'h0;

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} tbce_phase_type;
  typedef enum logic [2:0] {
    OP_NONE, OP_TOGGLE, OP_BR_SX, OP_BR_Z, OP_CALL, OP_CLEAR
  } tbce_op_type;

  // Program counter sum with bit 0 held low, words are aligned
  function automatic tbce_pc_type tbce_pc_add(input tbce_pc_type pc,
                                              input tbce_pc_type delta);
    tbce_pc_type sum;
    sum = pc + delta;
    return {sum[20:1], 1'b0};
  endfunction : tbce_pc_add

  // First-word decode into the instruction kind
  function automatic tbce_op_type tbce_decode(input tbce_word_type w);
    tbce_op_type op;
    op = OP_NONE;
    if (w[15:12] == OPC_TOGGLE)         op = OP_TOGGLE;
    else if (w[15:8] == OPC_BRANCH_SX)  op = OP_BR_SX;
    else if (w[15:8] == OPC_BRANCH_Z)   op = OP_BR_Z;
    else if (w[15:9] == OPC_CALL)       op = OP_CALL;
    else if (w[15:9] == OPC_CLEAR)      op = OP_CLEAR;
    return op;
  endfunction : tbce_decode

endpackage : tbce_pkg

`default_nettype wire

//--- design/tbce_addr_if.sv
// Operand address request and answer between executer and address former
`timescale 1ns/100ps
`default_nettype none

interface tbce_addr_if;
  import tbce_pkg::*;

  logic           bankBit;
  tbce_byte_type  fileAddr;
  tbce_bank_type  bankSel;
  logic           extEn;
  tbce_daddr_type indexBase;
  tbce_daddr_type operandAddr;
  logic           indexed;

  modport exec   (output bankBit, fileAddr, bankSel, extEn, indexBase,
                  input  operandAddr, indexed);
  modport former (input  bankBit, fileAddr, bankSel, extEn, indexBase,
                  output operandAddr, indexed);
endinterface : tbce_addr_if

`default_nettype wire

//--- design/tbce_addr_former.sv
// Data-memory operand address former: low bank, banked or indexed
`timescale 1ns/100ps
`default_nettype none

module tbce_addr_former (
  // Request and answer
  tbce_addr_if.former af
);
  import tbce_pkg::*;

  logic useIndex;

  // ==========================================================================
  // Address choice; indexing only ever replaces the low-bank form
  always_comb begin
    useIndex = af.extEn && !af.bankBit && (af.fileAddr <= INDEX_LIMIT);
    af.indexed = useIndex;
    if (useIndex) begin
      af.operandAddr = af.indexBase + {LOW_BANK, af.fileAddr};
    end else if (af.bankBit) begin
      af.operandAddr = {af.bankSel, af.fileAddr};
    end else begin
      af.operandAddr = {LOW_BANK, af.fileAddr};
    end
  end

endmodule : tbce_addr_former

`default_nettype wire

//--- design/tbce_exec.sv
// Four-phase decode and execute slice for toggle, branches, call and clear
`timescale 1ns/100ps
`default_nettype none

module tbce_exec (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // Instruction fetch
  input  wire tbce_pkg::tbce_word_type  instrWord,
  input  wire tbce_pkg::tbce_word_type  extWord,
  output logic                          phaseOne,
  output logic                          idleCycle,
  output tbce_pkg::tbce_pc_type         pcOut,
  // Addressing mode
  input  wire logic                     extInstrEn,
  input  wire tbce_pkg::tbce_daddr_type indexBase,
  // Core register loads from the rest of the core
  input  wire logic                     wLoadEn,
  input  wire tbce_pkg::tbce_byte_type  wLoadData,
  input  wire logic                     statusLoadEn,
  input  wire tbce_pkg::tbce_status_type statusLoadData,
  input  wire logic                     bankLoadEn,
  input  wire tbce_pkg::tbce_bank_type  bankLoadData,
  // Data memory
  output tbce_pkg::tbce_daddr_type      dmAddr,
  input  wire tbce_pkg::tbce_byte_type  dmRdData,
  output logic                          dmWrEn,
  output tbce_pkg::tbce_byte_type       dmWrData,
  // Core register and shadow state
  output tbce_pkg::tbce_byte_type       wOut,
  output tbce_pkg::tbce_status_type     statusOut,
  output tbce_pkg::tbce_bank_type       bankOut,
  output tbce_pkg::tbce_byte_type       accShadow,
  output tbce_pkg::tbce_status_type     statusShadow,
  output tbce_pkg::tbce_bank_type       bankShadow,
  // Return stack
  output logic                          stackPush,
  output tbce_pkg::tbce_pc_type         topOfStack
);
  import tbce_pkg::*;

  tbce_phase_type  phase_q;
  tbce_op_type     op_q;
  tbce_word_type   instr_q;
  tbce_pc_type     instrAddr_q;
  tbce_pc_type     pc_q;
  tbce_daddr_type  dmAddr_q;
  tbce_byte_type   rdByte_q;
  logic            dmWrEn_q;
  tbce_byte_type   dmWrData_q;
  logic            nopCycle_q;
  logic            brTaken_q;
  logic            stackPush_q;
  tbce_pc_type     retAddr_q;
  tbce_byte_type   w_q;
  tbce_status_type status_q;
  tbce_bank_type   bank_q;
  tbce_byte_type   wShadow_q;
  tbce_status_type statusShadow_q;
  tbce_bank_type   bankShadow_q;
  logic            isFileOp;
  logic            pcLoad;
  logic            brCond;
  tbce_pc_type     pcTarget;

  tbce_addr_if aIf ();

  // ==========================================================================
  // Operand address former, fed straight from the word being decoded
  assign aIf.bankBit   = instrWord[BANK_BIT];
  assign aIf.fileAddr  = instrWord[7:0];
  assign aIf.bankSel   = bank_q;
  assign aIf.extEn     = extInstrEn;
  assign aIf.indexBase = indexBase;

  tbce_addr_former uAddr (
    .af (aIf)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Phase counter, Q1 to Q4 and round again
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_Q1;
    end else begin
      case (phase_q)
        PH_Q1:   phase_q <= PH_Q2;
        PH_Q2:   phase_q <= PH_Q3;
        PH_Q3:   phase_q <= PH_Q4;
        default: phase_q <= PH_Q1;
      endcase
    end
  end

  // ==========================================================================
  // Decode in Q1; the idle cycle after a PC load decodes nothing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_q        <= OP_NONE;
      instr_q     <= WORD_RST;
      instrAddr_q <= PC_RST;
      dmAddr_q    <= DADDR_RST;
    end else if (phase_q == PH_Q1) begin
      if (nopCycle_q) begin
        op_q <= OP_NONE;
      end else begin
        op_q        <= tbce_decode(instrWord);
        instr_q     <= instrWord;
        instrAddr_q <= pc_q;
        dmAddr_q    <= aIf.operandAddr;
      end
    end
  end

  // Decoded kinds that touch a file byte
  assign isFileOp = (op_q == OP_TOGGLE) || (op_q == OP_CLEAR);
  // Flags are taken as they stand in Q3 of the branch itself
  assign brCond   = ((op_q == OP_BR_SX) && status_q[ST_EXCESS]) ||
                    ((op_q == OP_BR_Z) && status_q[ST_ZERO]);
  assign pcLoad   = brTaken_q || (op_q == OP_CALL);

  // Branch offset doubled and sign extended; call target from both words
  always_comb begin
    if (op_q == OP_CALL) begin
      pcTarget = {extWord[11:0], instr_q[7:0], 1'b0};
    end else begin
      pcTarget = tbce_pc_add(instrAddr_q,
                   PC_STEP + {{12{instr_q[7]}}, instr_q[7:0], 1'b0});
    end
  end

  // ==========================================================================
  // Branch decision, made in Q3 so the PC can be written in Q4
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      brTaken_q <= 1'b0;
    end else if (phase_q == PH_Q3) begin
      brTaken_q <= brCond;
    end else if (phase_q == PH_Q4) begin
      brTaken_q <= 1'b0;
    end
  end

  // Idle cycle marker: a loaded PC means the fetched word is stale
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nopCycle_q <= 1'b0;
    end else if (phase_q == PH_Q4) begin
      nopCycle_q <= pcLoad;
    end
  end

  // ==========================================================================
  // Program counter: step in Q1, jump in Q4
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_q <= PC_RST;
    end else if ((phase_q == PH_Q1) && !nopCycle_q) begin
      pc_q <= tbce_pc_add(pc_q, PC_STEP);
    end else if ((phase_q == PH_Q4) && pcLoad) begin
      pc_q <= {pcTarget[20:1], 1'b0};
    end
  end

  // ==========================================================================
  // Operand read in Q2, result formed in Q3, write strobe held through Q4
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdByte_q <= BYTE_ZERO;
    end else if (phase_q == PH_Q2) begin
      rdByte_q <= dmRdData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dmWrEn_q   <= 1'b0;
      dmWrData_q <= BYTE_ZERO;
    end else if (phase_q == PH_Q3) begin
      dmWrEn_q <= isFileOp;
      if (op_q == OP_TOGGLE) begin
        dmWrData_q <= rdByte_q ^ (8'h01 << instr_q[BIT_LSB +: 3]);
      end else begin
        dmWrData_q <= BYTE_ZERO;
      end
    end else begin
      dmWrEn_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Return stack push, visible as a strobe during Q3 of the call
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stackPush_q <= 1'b0;
      retAddr_q   <= PC_RST;
    end else if ((phase_q == PH_Q2) && (op_q == OP_CALL)) begin
      stackPush_q <= 1'b1;
      retAddr_q   <= tbce_pc_add(instrAddr_q, CALL_RET);
    end else begin
      stackPush_q <= 1'b0;
    end
  end

  // Shadow copy rides on the push; reads the values before any Q3 load
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wShadow_q      <= BYTE_ZERO;
      statusShadow_q <= STATUS_RST;
      bankShadow_q   <= BANK_RST;
    end else if ((phase_q == PH_Q3) && (op_q == OP_CALL) && instr_q[SHADOW_BIT]) begin
      wShadow_q      <= w_q;
      statusShadow_q <= status_q;
      bankShadow_q   <= bank_q;
    end
  end

  // ==========================================================================
  // Core registers; the clear's zero flag beats a load in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_q <= STATUS_RST;
    end else begin
      if (statusLoadEn) begin
        status_q <= statusLoadData;
      end
      if ((phase_q == PH_Q4) && (op_q == OP_CLEAR)) begin
        status_q[ST_ZERO] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      w_q <= BYTE_ZERO;
    end else if (wLoadEn) begin
      w_q <= wLoadData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bank_q <= BANK_RST;
    end else if (bankLoadEn) begin
      bank_q <= bankLoadData;
    end
  end

  // ==========================================================================
  // Outputs
  assign phaseOne     = (phase_q == PH_Q1);
  assign idleCycle    = nopCycle_q;
  assign pcOut        = pc_q;
  assign dmAddr       = dmAddr_q;
  assign dmWrEn       = dmWrEn_q;
  assign dmWrData     = dmWrData_q;
  assign wOut         = w_q;
  assign statusOut    = status_q;
  assign bankOut      = bank_q;
  assign accShadow    = wShadow_q;
  assign statusShadow = statusShadow_q;
  assign bankShadow   = bankShadow_q;
  assign stackPush    = stackPush_q;
  assign topOfStack   = retAddr_q;

  // ==========================================================================
  // Assertions
  sequence s_later_phases;
    (phase_q == PH_Q2) ##1 (phase_q == PH_Q3) ##1 (phase_q == PH_Q4);
  endsequence

  sequence s_branch_taken;
    (phase_q == PH_Q4) && brTaken_q;
  endsequence

  sequence s_call_q4;
    (phase_q == PH_Q4) && (op_q == OP_CALL);
  endsequence

  a_phase_order: assert property ((phase_q == PH_Q1) |=> s_later_phases)
    else $error("phases out of order");

  a_toggle_one_bit: assert property ((dmWrEn_q && (op_q == OP_TOGGLE)) |->
      ($countones(dmWrData_q ^ rdByte_q) == 1))
    else $error("toggle changed other than one bit");

  a_toggle_flags: assert property (((phase_q == PH_Q4) && (op_q == OP_TOGGLE)
      && !statusLoadEn) |=> $stable(statusOut))
    else $error("toggle altered status");

  a_low_bank: assert property (((phase_q == PH_Q1) && !nopCycle_q
      && !instrWord[BANK_BIT] && !(extInstrEn && (instrWord[7:0] <= INDEX_LIMIT)))
      |=> (dmAddr == {LOW_BANK, $past(instrWord[7:0])}) && !$past(aIf.indexed))
    else $error("low bank address wrong");

  a_banked_addr: assert property (((phase_q == PH_Q1) && !nopCycle_q
      && instrWord[BANK_BIT]) |=> (dmAddr == {$past(bank_q), $past(instrWord[7:0])}))
    else $error("banked address wrong");

  a_indexed_addr: assert property (((phase_q == PH_Q1) && !nopCycle_q
      && !instrWord[BANK_BIT] && extInstrEn && (instrWord[7:0] <= INDEX_LIMIT))
      |=> (dmAddr == $past(indexBase) + {LOW_BANK, $past(instrWord[7:0])}) && $past(aIf.indexed))
    else $error("indexed address wrong");

  a_branch_untaken: assert property (((phase_q == PH_Q3)
      && ((op_q == OP_BR_SX) || (op_q == OP_BR_Z)) && !brCond)
      |=> ##1 ($stable(pcOut) ##1 !idleCycle))
    else $error("untaken branch moved PC");

  a_branch_target: assert property (s_branch_taken |=>
      (pcOut == tbce_pc_add($past(instrAddr_q),
                PC_STEP + {{12{$past(instr_q[7])}}, $past(instr_q[7:0]), 1'b0})))
    else $error("branch target wrong");

  a_branch_idle: assert property (s_branch_taken |=>
      (idleCycle && !dmWrEn) ##1 ($stable(pcOut) && !stackPush)[*4])
    else $error("taken branch idle cycle wrong");

  a_call_target: assert property (s_call_q4 |=>
      (pcOut == {$past(extWord[11:0]), $past(instr_q[7:0]), 1'b0}) && idleCycle)
    else $error("call target wrong");

  a_call_push: assert property (((phase_q == PH_Q3) && (op_q == OP_CALL)) |->
      (stackPush && (topOfStack == tbce_pc_add(instrAddr_q, CALL_RET))))
    else $error("call push wrong");

  a_shadow_copy: assert property (((phase_q == PH_Q3) && (op_q == OP_CALL)
      && instr_q[SHADOW_BIT]) |=> ((accShadow == $past(wOut))
      && (statusShadow == $past(statusOut)) && (bankShadow == $past(bankOut))))
    else $error("shadow copy wrong");

  a_shadow_keep: assert property (((op_q == OP_CALL) && !instr_q[SHADOW_BIT])
      |=> ($stable(accShadow) && $stable(statusShadow) && $stable(bankShadow)))
    else $error("shadows changed without s");

  a_clear_byte: assert property (((phase_q == PH_Q4) && (op_q == OP_CLEAR)) |->
      (dmWrEn && (dmWrData == BYTE_ZERO)) ##1 statusOut[ST_ZERO])
    else $error("clear did not zero byte or set zero flag");

  a_pc_even: assert property (!pcOut[0])
    else $error("PC bit 0 set");

endmodule : tbce_exec

`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the toggle, branch, call and clear slice
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import tbce_pkg::*;

  // ==========================================================================
  // Design connections and bench state
  logic            mclk;
  logic            rst;
  tbce_word_type   instrWord;
  tbce_word_type   extWord;
  logic            phaseOne;
  logic            idleCycle;
  tbce_pc_type     pcOut;
  logic            extInstrEn;
  tbce_daddr_type  indexBase;
  logic            wLoadEn;
  tbce_byte_type   wLoadData;
  logic            statusLoadEn;
  tbce_status_type statusLoadData;
  logic            bankLoadEn;
  tbce_bank_type   bankLoadData;
  tbce_daddr_type  dmAddr;
  tbce_byte_type   dmRdData;
  logic            dmWrEn;
  tbce_byte_type   dmWrData;
  tbce_byte_type   wOut;
  tbce_status_type statusOut;
  tbce_bank_type   bankOut;
  tbce_byte_type   accShadow;
  tbce_status_type statusShadow;
  tbce_bank_type   bankShadow;
  logic            stackPush;
  tbce_pc_type     topOfStack;
  tbce_byte_type   mem [0:4095];
  int              errCount;
  int              numChecks;

  // ==========================================================================
  // Clock, data memory model and design
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // Reads are combinational so the byte is settled well before Q2 ends
  assign dmRdData = mem[dmAddr];
  always @(posedge mclk) begin
    if (dmWrEn === 1'b1) mem[dmAddr] <= dmWrData;
  end

  tbce_exec uut (
    .mclk(mclk), .rst(rst), .instrWord(instrWord), .extWord(extWord),
    .phaseOne(phaseOne), .idleCycle(idleCycle), .pcOut(pcOut),
    .extInstrEn(extInstrEn), .indexBase(indexBase),
    .wLoadEn(wLoadEn), .wLoadData(wLoadData), .statusLoadEn(statusLoadEn),
    .statusLoadData(statusLoadData), .bankLoadEn(bankLoadEn), .bankLoadData(bankLoadData),
    .dmAddr(dmAddr), .dmRdData(dmRdData), .dmWrEn(dmWrEn), .dmWrData(dmWrData),
    .wOut(wOut), .statusOut(statusOut), .bankOut(bankOut), .accShadow(accShadow),
    .statusShadow(statusShadow), .bankShadow(bankShadow),
    .stackPush(stackPush), .topOfStack(topOfStack)
  );

  // ==========================================================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Always leaves the bench just after an edge, so drives never race it
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic loadCore(input tbce_byte_type w, input tbce_status_type s,
                          input tbce_bank_type b);
    wLoadEn        = 1'b1;
    wLoadData      = w;
    statusLoadEn   = 1'b1;
    statusLoadData = s;
    bankLoadEn     = 1'b1;
    bankLoadData   = b;
    step(1);
    wLoadEn      = 1'b0;
    statusLoadEn = 1'b0;
    bankLoadEn   = 1'b0;
  endtask : loadCore

  // Waits for a decode slot, presents the first and second words, returns just after decode
  task automatic issue(input tbce_word_type w, input tbce_word_type x,
                       output tbce_pc_type pc0);
    int guard;
    guard = 0;
    while (!(phaseOne === 1'b1 && idleCycle === 1'b0) && guard < 16) begin
      step(1);
      guard++;
    end
    chk(guard < 16, 1'b1);
    pc0       = pcOut;
    instrWord = w;
    extWord   = x;
    step(1);
    instrWord = 16'h0000;
  endtask : issue

  // ==========================================================================
  // Scenarios
  task automatic testToggle();
    tbce_pc_type     pc0;
    tbce_status_type st0;
    loadCore(8'h11, 5'h0A, 4'h3);
    mem[12'h3A5] = 8'h75;
    st0 = statusOut;
    issue(16'h79A5, 16'h0000, pc0);
    chk(dmAddr, 12'h3A5);
    step(2);
    chk(dmWrEn, 1'b1);
    chk(dmWrData, 8'h65);
    step(1);
    chk(dmWrEn, 1'b0);
    chk(mem[12'h3A5], 8'h65);
    chk(statusOut, st0);
    $display("test toggle done");
  endtask : testToggle

  // Low bank, indexed and the first address past the indexed range
  task automatic testAddressing();
    logic [0:2]     ext = 3'b011;
    tbce_byte_type  f [0:2] = '{8'h80, 8'h5F, 8'h60};
    tbce_daddr_type ea [0:2] = '{12'h080, 12'h25F, 12'h060};
    tbce_pc_type    pc0;
    indexBase = 12'h200;
    for (int i = 0; i < 3; i++) begin
      extInstrEn = ext[i];
      loadCore(8'h00, 5'h00, 4'h3);
      mem[ea[i]] = 8'hA5;
      mem[{4'h3, f[i]}] = 8'h3C;
      issue({8'h6A, f[i]}, 16'h0000, pc0);
      chk(dmAddr, ea[i]);
      step(3);
      chk(mem[ea[i]], 8'h00);
      chk(mem[{4'h3, f[i]}], 8'h3C);
      chk(statusOut[ST_ZERO], 1'b1);
    end
    extInstrEn = 1'b0;
    $display("test addressing done");
  endtask : testAddressing

  task automatic testBranch();
    tbce_byte_type   opc [0:3] = '{8'hE4, 8'hE4, 8'hE0, 8'hE0};
    tbce_status_type st [0:3]  = '{5'h08, 5'h04, 5'h04, 5'h08};
    tbce_byte_type   off [0:3] = '{8'h7F, 8'h10, 8'h80, 8'h10};
    logic [0:3]      tkn = 4'b1010;
    tbce_pc_type     pc0;
    tbce_pc_type     tgt;
    for (int i = 0; i < 4; i++) begin
      loadCore(8'h00, st[i], 4'h0);
      issue({opc[i], off[i]}, 16'h0000, pc0);
      tgt = pc0 + 21'h000002 + {{12{off[i][7]}}, off[i], 1'b0};
      step(3);
      chk(pcOut, tkn[i] ? tgt : pc0 + 21'h000002);
      chk(pcOut[0], 1'b0);
      chk(idleCycle, tkn[i]);
      chk(statusOut, st[i]);
      if (tkn[i]) begin
        step(4);
        chk(idleCycle, 1'b0);
        chk(pcOut, tgt);
      end
    end
    $display("test branch done");
  endtask : testBranch

  task automatic doCall(input tbce_word_type w1, input tbce_word_type w2,
                        input tbce_pc_type tgt);
    tbce_pc_type pc0;
    issue(w1, w2, pc0);
    step(1);
    chk(stackPush, 1'b1);
    step(1);
    chk(stackPush, 1'b0);
    chk(topOfStack, pc0 + 21'h000004);
    step(1);
    chk(pcOut, tgt);
    chk(idleCycle, 1'b1);
    step(4);
    chk(idleCycle, 1'b0);
    chk({accShadow, statusShadow, bankShadow}, {8'h5A, 5'h0C, 4'h9});
  endtask : doCall

  // Second call has the shadow bit clear, so the first call's copies remain
  task automatic testCall();
    loadCore(8'h5A, 5'h0C, 4'h9);
    doCall(16'hED34, 16'hF123, 21'h024668);
    loadCore(8'hC3, 5'h13, 4'h6);
    doCall(16'hEC00, 16'hFFFF, 21'h1FFE00);
    chk({wOut, statusOut, bankOut}, {8'hC3, 5'h13, 4'h6});
    $display("test call done");
  endtask : testCall

  // ==========================================================================
  // Verdict, watchdog and main sequence
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : giveVerdict

  // Whole run is under two hundred cycles; allow ample margin
  initial begin
    #(25.0 * 3000);
    errCount++;
    $display("[ERR] t=%0t watchdog expired", $time);
    giveVerdict();
  end

  initial begin
    errCount  = 0;
    numChecks = 0;
    rst = 1'b1;
    instrWord = 16'h0000;
    extWord = 16'h0000;
    extInstrEn = 1'b0;
    indexBase = 12'h000;
    wLoadEn = 1'b0;
    wLoadData = 8'h00;
    statusLoadEn = 1'b0;
    statusLoadData = 5'h00;
    bankLoadEn = 1'b0;
    bankLoadData = 4'h0;
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    testToggle();
    testAddressing();
    testBranch();
    testCall();
    giveVerdict();
  end

endmodule : tb_top

`default_nettype wire
